/* File: glyph_attribute_control_regs.sv */
/*
  Register bank of an eight digit dot matrix display controller: glyph
  pointer, custom glyph memory, flash attribute RAM, character RAM and the
  control word with its clear and self-test sequences.
  Assumes host bus pins synchronous to the refresh clock, and an external
  character decoder ROM answering romDots combinationally for romAddr.
*/
`timescale 1ns/1ps
module glyph_attribute_control_regs import glyph_attr_pkg::*; #(
  parameter int FLASH_DIV = FLASH_DIVIDE,
  parameter int SELFTEST_CYCLES = SELFTEST_PERIODS,
  parameter logic [34:0] ROM_EXPECTED_SUM = 35'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Host bus
  input wire logic chipSelB,
  input wire logic writeB,
  input wire logic readB,
  input wire logic attribute_ram_select,
  input wire logic [4:0] addr,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOeB,
  // Scan readout
  input wire logic [2:0] scanDigit,
  input wire logic [2:0] scanRow,
  output logic scanIsGlyph,
  output logic [6:0] scanCode,
  output logic [4:0] scanGlyphDots,
  // Display drive
  output logic [7:0] digitLit,
  output logic dutyOn,
  output logic testActive,
  output logic testInverse,
  // Decoder ROM test port
  output logic [6:0] romAddr,
  input wire logic [34:0] romDots,
  // Status
  output logic busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int TEST_W = $clog2(SELFTEST_CYCLES + 1);
  localparam logic [TEST_W-1:0] TEST_LAST = TEST_W'(SELFTEST_CYCLES - 1);
  localparam logic [TEST_W-1:0] ROM_DONE = TEST_W'(ROM_CODES);
  localparam logic [TEST_W-1:0] PATTERN_SWAP = TEST_W'(ROM_CODES + (SELFTEST_CYCLES - ROM_CODES) / 2);

  typedef enum logic [2:0] {
    T_POINTER = 3'b000,
    T_GLYPH = 3'b001,
    T_CONTROL = 3'b010,
    T_CHAR = 3'b011,
    T_FLASH = 3'b100
  } target_e;

  op_state_e state_ff, nxt_state;
  logic [7:0] control_ff, nxt_control;
  logic [7:0] flashRam_ff, nxt_flashRam;
  logic [7:0] charRam_ff [DIGITS];
  logic [7:0] nxt_charRam [DIGITS];
  logic [1:0] clearCnt_ff, nxt_clearCnt;
  logic [TEST_W-1:0] testCnt_ff, nxt_testCnt;
  logic [34:0] romSum_ff, nxt_romSum;
  logic [7:0] dataOut_ff, nxt_dataOut;
  logic wrActive_ff, rdActive_ff;
  logic [7:0] pointer_ff;
  logic [4:0] glyphMem [GLYPH_SLOTS][GLYPH_ROWS];
  logic scanIsGlyph_ff;
  logic [6:0] scanCode_ff;
  logic [4:0] scanGlyphDots_ff;
  logic [7:0] digitLit_ff, nxt_digitLit;
  logic wrNow, rdNow, wrEdge, rdEdge, phaseOff;
  target_e target;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // pointer at upper bits 00
  // glyph rows at upper bits 01
  // attribute select low ignores upper bits
  function automatic target_e decode(input logic sel, input logic [1:0] upper);
    if (!sel) begin
      decode = T_FLASH;
    end else begin
      case (upper)
        UPPER_POINTER: decode = T_POINTER;
        UPPER_GLYPH: decode = T_GLYPH;
        UPPER_CONTROL: decode = T_CONTROL;
        default: decode = T_CHAR;
      endcase
    end
  endfunction

  assign target = decode(attribute_ram_select, addr[4:3]);

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  // strobe combinations
  assign wrNow = !chipSelB && !writeB && readB;
  assign rdNow = !chipSelB && !readB && writeB;
  // one access per strobe, taken on its registered leading edge
  // writes during clear or test are ignored; reads are still served
  assign wrEdge = wrNow && !wrActive_ff && (state_ff == IDLE);
  assign rdEdge = rdNow && !rdActive_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrActive_ff <= 1'b0;
      rdActive_ff <= 1'b0;
    end else begin
      wrActive_ff <= wrNow;
      rdActive_ff <= rdNow;
    end
  end

  // ----------------------------------------------------------------
  // Glyph pointer and glyph memory (kept over reset)
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    // pointer to all ones at test end
    if (state_ff == TESTING && testCnt_ff == TEST_LAST) begin
      pointer_ff <= POINTER_AFTER_TEST;
    // full byte stored, low nibble used
    end else if (wrEdge && target == T_POINTER) begin
      pointer_ff <= dataIn;
    end
    if (wrEdge && target == T_GLYPH && addr[2:0] < 3'(GLYPH_ROWS)) begin
      glyphMem[pointer_ff[3:0]][addr[2:0]] <= dataIn[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Control, attribute RAM, character RAM and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_control = control_ff;
    nxt_flashRam = flashRam_ff;
    nxt_charRam = charRam_ff;
    nxt_clearCnt = clearCnt_ff;
    nxt_testCnt = testCnt_ff;
    nxt_romSum = romSum_ff;
    case (state_ff)
      IDLE: begin
        if (wrEdge) begin
          case (target)
            // whole word replaced; result bit stays read-only
            T_CONTROL: begin
              nxt_control = dataIn;
              nxt_control[RESULT_BIT] = control_ff[RESULT_BIT];
              if (dataIn[TEST_BIT]) begin
                nxt_state = TESTING;
                nxt_testCnt = '0;
                nxt_romSum = '0;
              end else if (dataIn[CLEAR_BIT]) begin
                nxt_state = CLEARING;
                nxt_clearCnt = 2'h1;
              end
            end
            // attribute bit from data bit zero
            T_FLASH: nxt_flashRam[addr[2:0]] = dataIn[0];
            T_CHAR: nxt_charRam[addr[2:0]] = dataIn;
            default: ;
          endcase
        end
      end
      CLEARING: begin
        // three cycles, then bit 7 drops
        if (clearCnt_ff == CLEAR_CYCLES) begin
          nxt_state = IDLE;
          nxt_control[CLEAR_BIT] = 1'b0;
          nxt_flashRam = FLASH_CLEAR_FILL;
          for (int i = 0; i < DIGITS; i++) begin
            nxt_charRam[i] = SPACE_CODE;
          end
        end else begin
          nxt_clearCnt = clearCnt_ff + 2'h1;
        end
      end
      TESTING: begin
        nxt_testCnt = testCnt_ff + 1'b1;
        // fold every ROM output into the checksum
        if (testCnt_ff < ROM_DONE) begin
          nxt_romSum = {romSum_ff[33:0], romSum_ff[34]} ^ romDots;
        end
        if (testCnt_ff == ROM_DONE) begin
          nxt_control[RESULT_BIT] = (romSum_ff == ROM_EXPECTED_SUM);
        end
        if (testCnt_ff == TEST_LAST) begin
          nxt_state = IDLE;
          nxt_control = CONTROL_RESET;
          nxt_control[RESULT_BIT] = control_ff[RESULT_BIT];
          nxt_flashRam = FLASH_RESET;
          for (int i = 0; i < DIGITS; i++) begin
            nxt_charRam[i] = SPACE_CODE;
          end
        end
      end
      default: nxt_state = IDLE;
    endcase
  end

  // reset loads spaces and zeroes flash and control
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= IDLE;
      control_ff <= CONTROL_RESET;
      flashRam_ff <= FLASH_RESET;
      for (int i = 0; i < DIGITS; i++) begin
        charRam_ff[i] <= SPACE_CODE;
      end
      clearCnt_ff <= 2'h0;
      testCnt_ff <= '0;
      romSum_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      control_ff <= nxt_control;
      flashRam_ff <= nxt_flashRam;
      charRam_ff <= nxt_charRam;
      clearCnt_ff <= nxt_clearCnt;
      testCnt_ff <= nxt_testCnt;
      romSum_ff <= nxt_romSum;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_dataOut = dataOut_ff;
    if (rdEdge) begin
      case (target)
        T_POINTER: nxt_dataOut = pointer_ff;
        T_GLYPH: nxt_dataOut = {3'h0, glyphMem[pointer_ff[3:0]][addr[2:0]]};
        T_CONTROL: nxt_dataOut = control_ff;
        T_CHAR: nxt_dataOut = charRam_ff[addr[2:0]];
        T_FLASH: nxt_dataOut = {7'h00, flashRam_ff[addr[2:0]]};
        default: nxt_dataOut = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataOut_ff <= 8'h00;
    end else begin
      dataOut_ff <= nxt_dataOut;
    end
  end

  // Data lags the strobe by one cycle; the bus is driven only while it is held
  assign dataOut = dataOut_ff;
  assign dataOeB = !(rdNow && rdActive_ff);

  // ----------------------------------------------------------------
  // Display timing and digit visibility
  // ----------------------------------------------------------------
  blink_duty_timer #(
    .FLASH_DIV(FLASH_DIV)
  ) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .brightCode(control_ff[BRIGHT_MSB:BRIGHT_LSB]),
    .phaseOff(phaseOff),
    .dutyOn(dutyOn)
  );

  generate
    for (genvar d = 0; d < DIGITS; d++) begin : g_digit
      always_comb begin
        if (control_ff[BLINK_BIT]) begin
          nxt_digitLit[d] = !phaseOff;
        // without blink, flash only when enabled and flagged
        end else if (control_ff[FLASH_EN_BIT] && flashRam_ff[d]) begin
          nxt_digitLit[d] = !phaseOff;
        end else begin
          nxt_digitLit[d] = 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Scan readout and test outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      digitLit_ff <= 8'h00;
      scanIsGlyph_ff <= 1'b0;
      scanCode_ff <= 7'h00;
      scanGlyphDots_ff <= 5'h00;
    end else begin
      digitLit_ff <= nxt_digitLit;
      // top bit picks glyph slot or ROM code
      scanIsGlyph_ff <= charRam_ff[scanDigit][7];
      scanCode_ff <= charRam_ff[scanDigit][6:0];
      scanGlyphDots_ff <= charRam_ff[scanDigit][7]
                          ? glyphMem[charRam_ff[scanDigit][3:0]][scanRow] : 5'h00;
    end
  end

  assign digitLit = digitLit_ff;
  assign scanIsGlyph = scanIsGlyph_ff;
  assign scanCode = scanCode_ff;
  assign scanGlyphDots = scanGlyphDots_ff;
  assign romAddr = testCnt_ff[6:0];
  assign testActive = (state_ff == TESTING) && (testCnt_ff >= ROM_DONE);
  assign testInverse = testActive && (testCnt_ff >= PATTERN_SWAP);
  assign busy = (state_ff != IDLE);

endmodule

/* File: glyph_attr_pkg.sv */
/*
  Shared constants for the glyph and attribute control block:
  address decode codes, control word fields, reset values and timing counts.
  Assumes a single refresh clock of 50 MHz driving the whole block.
*/
package glyph_attr_pkg;

  // ----------------------------------------------------------------
  // Address decode (upper address pair, with the attribute select high)
  // ----------------------------------------------------------------
  localparam logic [1:0] UPPER_POINTER = 2'h0;
  localparam logic [1:0] UPPER_GLYPH = 2'h1;
  localparam logic [1:0] UPPER_CONTROL = 2'h2;
  localparam logic [1:0] UPPER_CHAR = 2'h3;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int BRIGHT_LSB = 0;
  localparam int BRIGHT_MSB = 2;
  localparam int FLASH_EN_BIT = 3;
  localparam int BLINK_BIT = 4;
  localparam int RESULT_BIT = 5;
  localparam int TEST_BIT = 6;
  localparam int CLEAR_BIT = 7;

  // ----------------------------------------------------------------
  // Reset and fill values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] FLASH_RESET = 8'h00;
  localparam logic [7:0] FLASH_CLEAR_FILL = 8'hff;
  localparam logic [7:0] POINTER_AFTER_TEST = 8'hff;
  localparam int GLYPH_SLOTS = 16;
  localparam int GLYPH_ROWS = 7;
  localparam int DIGITS = 8;

  // ----------------------------------------------------------------
  // Timing, in refresh clock cycles
  // ----------------------------------------------------------------
  localparam int FLASH_DIVIDE = 28672;
  localparam int SELFTEST_PERIODS = 262144;
  localparam logic [1:0] CLEAR_CYCLES = 2'h3;
  localparam int ROM_CODES = 128;
  localparam int DUTY_PERIOD = 15;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    CLEARING = 3'b010,
    TESTING = 3'b100
  } op_state_e;

endpackage

/* File: blink_duty_timer.sv */
/*
  Flash and blink phase divider plus brightness duty generator.
  Assumes the refresh clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module blink_duty_timer import glyph_attr_pkg::*; #(
  parameter int FLASH_DIV = FLASH_DIVIDE
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Brightness code
  input wire logic [2:0] brightCode,
  // Timing outputs
  output logic phaseOff,
  output logic dutyOn
);

  localparam int DIV_W = $clog2(FLASH_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FLASH_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(FLASH_DIV / 2);
  localparam logic [3:0] DUTY_LAST = 4'(DUTY_PERIOD - 1);

  logic [DIV_W-1:0] divCnt_ff, nxt_divCnt;
  logic [3:0] dutyCnt_ff, nxt_dutyCnt;
  logic phaseOff_ff, nxt_phaseOff;
  logic dutyOn_ff, nxt_dutyOn;

  // Lit slots out of fifteen: 100, 80, 53, 40, 27, 20, 13 percent, blank
  function automatic logic [3:0] dutySlots(input logic [2:0] code);
    case (code)
      3'h0: dutySlots = 4'hf;
      3'h1: dutySlots = 4'hc;
      3'h2: dutySlots = 4'h8;
      3'h3: dutySlots = 4'h6;
      3'h4: dutySlots = 4'h4;
      3'h5: dutySlots = 4'h3;
      3'h6: dutySlots = 4'h2;
      default: dutySlots = 4'h0;
    endcase
  endfunction

  always_comb begin
    nxt_divCnt = (divCnt_ff == DIV_LAST) ? '0 : divCnt_ff + 1'b1;
    nxt_phaseOff = (nxt_divCnt >= DIV_HALF);
    nxt_dutyCnt = (dutyCnt_ff == DUTY_LAST) ? 4'h0 : dutyCnt_ff + 4'h1;
    nxt_dutyOn = (nxt_dutyCnt < dutySlots(brightCode));
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_ff <= '0;
      dutyCnt_ff <= 4'h0;
      phaseOff_ff <= 1'b0;
      dutyOn_ff <= 1'b0;
    end else begin
      divCnt_ff <= nxt_divCnt;
      dutyCnt_ff <= nxt_dutyCnt;
      phaseOff_ff <= nxt_phaseOff;
      dutyOn_ff <= nxt_dutyOn;
    end
  end

  assign phaseOff = phaseOff_ff;
  assign dutyOn = dutyOn_ff;

endmodule

/* File: glyph_attr_props.sv */
/*
  Checker for the glyph and attribute control block: strobe handling,
  clear and self-test timing, read drive.
  Assumes one refresh clock domain; bound to every instance of the block.
*/
`timescale 1ns/1ps
module glyph_attr_props import glyph_attr_pkg::*; #(
  parameter int SELFTEST_CYCLES = SELFTEST_PERIODS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Host bus
  input wire logic chipSelB,
  input wire logic writeB,
  input wire logic readB,
  input wire logic attribute_ram_select,
  input wire logic [4:0] addr,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOeB,
  // Sequencer
  input wire logic testActive,
  input wire logic testInverse,
  input wire logic [6:0] romAddr,
  input wire logic busy
);
  localparam int HALF_POINT = 128 + (SELFTEST_CYCLES - 128) / 2;
  // --------
  // Strobe history and busy run length
  // --------
  logic wrNow, rdNow, ctlTake, startReq;
  logic wrPrev_ff, rdPrev_ff, nxt_wrPrev, nxt_rdPrev;
  logic [19:0] runLen_ff, nxt_runLen;
  assign wrNow = !chipSelB && !writeB && readB;
  assign rdNow = !chipSelB && !readB && writeB;
  assign ctlTake = wrNow && !wrPrev_ff && !busy && attribute_ram_select
    && addr[4:3] == UPPER_CONTROL;
  assign startReq = ctlTake && (dataIn[TEST_BIT] || dataIn[CLEAR_BIT]);
  always_comb begin
    nxt_wrPrev = wrNow;
    nxt_rdPrev = rdNow;
    nxt_runLen = busy ? runLen_ff + 20'h1 : 20'h0;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPrev_ff <= 1'b0;
      rdPrev_ff <= 1'b0;
      runLen_ff <= 20'h0;
    end else begin
      wrPrev_ff <= nxt_wrPrev;
      rdPrev_ff <= nxt_rdPrev;
      runLen_ff <= nxt_runLen;
    end
  end
  // --------
  // Properties
  // --------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence clearRun;
    busy [*3] ##1 !busy;
  endsequence
  sequence sweepStart;
    (busy && romAddr == 7'h0) ##1 (busy && romAddr == 7'h1);
  endsequence
  AST_CLEAR_BUSY: assert property (
    ctlTake && dataIn[CLEAR_BIT] && !dataIn[TEST_BIT] |=> clearRun)
    else $error("clear did not run three cycles");
  AST_TEST_START: assert property (ctlTake && dataIn[TEST_BIT] |=> sweepStart)
    else $error("self-test did not start its decoder sweep");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(startReq))
    else $error("busy rose without a start request");
  AST_BUSY_LENGTH: assert property (
    $fell(busy) |-> runLen_ff == 20'h3 || runLen_ff == SELFTEST_CYCLES)
    else $error("busy run has the wrong length");
  AST_ROM_SWEEP: assert property (
    busy && runLen_ff >= 20'h3 && runLen_ff < 20'd128 |-> romAddr == runLen_ff[6:0])
    else $error("decoder sweep address out of step");
  AST_PATTERN_START: assert property (
    busy && runLen_ff == 20'd127 |=> testActive && !testInverse)
    else $error("pattern phase did not begin after the sweep");
  AST_INVERSE_HALF: assert property ($rose(testInverse) |-> runLen_ff == HALF_POINT)
    else $error("inverse pattern began at the wrong time");
  AST_OE_DRIVE: assert property (rdNow && rdPrev_ff |-> !dataOeB)
    else $error("read data not driven");
  AST_OE_RELEASE: assert property (!rdNow |-> dataOeB)
    else $error("data driven without a read");
  AST_DATA_HOLD: assert property (!(rdNow && !rdPrev_ff) |=> $stable(dataOut))
    else $error("read data changed without a read");
endmodule
bind glyph_attribute_control_regs glyph_attr_props #(
  .SELFTEST_CYCLES(SELFTEST_CYCLES)
) glyph_attr_props_i (
  .clock(clock), .rst_b(rst_b), .chipSelB(chipSelB), .writeB(writeB), .readB(readB),
  .attribute_ram_select(attribute_ram_select), .addr(addr), .dataIn(dataIn),
  .dataOut(dataOut), .dataOeB(dataOeB), .testActive(testActive),
  .testInverse(testInverse), .romAddr(romAddr), .busy(busy)
);

/* File: host_bus_model.sv */
/*
  Behavioural host processor on the eight-bit parallel display bus.
  Assumes the bench calls one task at a time, in the refresh clock domain.
*/
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input wire logic clock,
  // Bus toward the display
  output logic chipSelB,
  output logic writeB,
  output logic readB,
  output logic attribute_ram_select,
  output logic [4:0] addr,
  output logic [7:0] dataIn,
  input wire logic [7:0] dataOut
);
  initial begin
    chipSelB = 1'b1;
    writeB = 1'b1;
    readB = 1'b1;
    attribute_ram_select = 1'b1;
    addr = 5'h00;
    dataIn = 8'h00;
  end
  task automatic wr(input logic sel, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    attribute_ram_select = sel;
    addr = a;
    dataIn = d;
    chipSelB = 1'b0;
    writeB = 1'b0;
    @(posedge clock);
    #1;
    chipSelB = 1'b1;
    writeB = 1'b1;
    // Released data must not still look valid
    dataIn = ~d;
  endtask
  task automatic rd(input logic sel, input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    attribute_ram_select = sel;
    addr = a;
    chipSelB = 1'b0;
    readB = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    d = dataOut;
    chipSelB = 1'b1;
    readB = 1'b1;
  endtask
endmodule

/* File: glyph_attribute_control_regs_tb.sv */
/*
  Self-checking bench for the glyph and attribute control block.
  Assumes the host model, the checker bind and a shortened test length.
*/
`timescale 1ns/1ps
module glyph_attribute_control_regs_tb import glyph_attr_pkg::*; ;
  localparam int TEST_LEN = 300;
  logic clock, rst_b, chipSelB, writeB, readB, attribute_ram_select, dataOeB;
  logic [4:0] addr;
  logic [7:0] dataIn, dataOut, digitLit;
  logic [7:0] busData;
  // Released bus shows the inverse, so a read taken undriven fails
  assign busData = dataOeB ? ~dataOut : dataOut;
  logic [2:0] scanDigit, scanRow;
  logic scanIsGlyph, dutyOn, testActive, testInverse, busy, romPat;
  logic [6:0] scanCode, romAddr;
  logic [4:0] scanGlyphDots;
  logic [34:0] romDots;
  logic [31:0] seed;
  int err_total, tests_run, ctrlM, ptrM;
  int charM[8], flashM[8], glyphM[16][7];
  int lit[8] = '{15, 12, 8, 6, 4, 3, 2, 0};
  assign romDots = romPat ? {28'h0, romAddr} : 35'h0;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  host_bus_model host_bus_model_i (
    .clock(clock), .chipSelB(chipSelB), .writeB(writeB), .readB(readB),
    .attribute_ram_select(attribute_ram_select), .addr(addr), .dataIn(dataIn),
    .dataOut(busData)
  );
  glyph_attribute_control_regs #(
    .FLASH_DIV(8),
    .SELFTEST_CYCLES(TEST_LEN)
  ) glyph_attribute_control_regs_i (
    .clock(clock), .rst_b(rst_b), .chipSelB(chipSelB), .writeB(writeB), .readB(readB),
    .attribute_ram_select(attribute_ram_select), .addr(addr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOeB(dataOeB), .scanDigit(scanDigit), .scanRow(scanRow),
    .scanIsGlyph(scanIsGlyph), .scanCode(scanCode), .scanGlyphDots(scanGlyphDots),
    .digitLit(digitLit), .dutyOn(dutyOn), .testActive(testActive),
    .testInverse(testInverse), .romAddr(romAddr), .romDots(romDots), .busy(busy)
  );
  // --------
  // Helpers
  // --------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wc(input logic [7:0] v);
    host_bus_model_i.wr(1'b1, 5'h10, v);
    ctrlM = (v & 8'hdf) | (ctrlM & 8'h20);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    host_bus_model_i.rd(1'b1, a, d);
    chk({8'h0, d & m}, {8'h0, e & m});
  endtask
  task automatic idle(input int exp);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(16'(n), 16'(exp));
  endtask
  task automatic scanChk(input int d, input int r);
    logic [7:0] c;
    c = 8'(charM[d]);
    scanDigit = 3'(d);
    scanRow = 3'(r);
    repeat (2) @(posedge clock);
    #1;
    chk({15'h0, scanIsGlyph}, {15'h0, c[7]});
    if (c[7]) chk({11'h0, scanGlyphDots}, 16'(glyphM[c[3:0]][r] & 8'h1f));
    else chk({9'h0, scanCode}, {9'h0, c[6:0]});
  endtask
  task automatic flashChk();
    logic [7:0] off, e;
    off = 8'h0;
    for (int i = 0; i < 8; i++) e[i] = ctrlM[4] | (ctrlM[3] & flashM[i][0]);
    repeat (3) @(posedge clock);
    repeat (24) begin
      @(posedge clock);
      #1;
      off = off | ~digitLit;
    end
    chk({8'h0, off}, {8'h0, e});
  endtask
  task automatic blankModel(input int f);
    for (int i = 0; i < 8; i++) begin
      charM[i] = 8'h20;
      flashM[i] = f;
    end
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    int n;
    logic [34:0] s;
    seed = 32'h24;
    err_total = 0;
    tests_run = 0;
    rst_b = 1'b0;
    scanDigit = 3'h0;
    scanRow = 3'h0;
    romPat = 1'b0;
    ctrlM = 0;
    blankModel(0);
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1'b1;
    rdc(5'h10, 8'h00, 8'hff);
    for (int i = 0; i < 8; i++) rdc({2'b11, i[2:0]}, 8'h20, 8'hff);
    for (int k = 0; k < 2; k++) begin
      ptrM = int'(rnd() & 32'hff);
      host_bus_model_i.wr(1'b1, {2'b00, 3'(rnd())}, 8'(ptrM));
      for (int r = 0; r < 7; r++) begin
        glyphM[ptrM[3:0]][r] = int'(rnd() & 32'hff);
        host_bus_model_i.wr(1'b1, {2'b01, r[2:0]}, 8'(glyphM[ptrM[3:0]][r]));
      end
      host_bus_model_i.wr(1'b1, 5'h0f, 8'(rnd()));
      charM[k] = 8'h80 | int'(rnd() & 32'h70) | ptrM[3:0];
      host_bus_model_i.wr(1'b1, {2'b11, k[2:0]}, 8'(charM[k]));
      for (int r = 0; r < 7; r++) scanChk(k, r);
      rdc(5'(rnd() & 32'h7), 8'(ptrM), 8'h0f);
    end
    charM[2] = int'(rnd() & 32'h7f);
    host_bus_model_i.wr(1'b1, 5'h1a, 8'(charM[2]));
    scanChk(2, 3);
    for (int i = 0; i < 8; i++) begin
      flashM[i] = int'(rnd() & 32'h1);
      host_bus_model_i.wr(1'b0, {2'(rnd()), i[2:0]}, 8'(rnd()) & 8'hfe | 8'(flashM[i]));
    end
    wc(8'h08);
    flashChk();
    wc(8'h18);
    flashChk();
    wc(8'h00);
    flashChk();
    repeat (4) begin
      wc(8'(rnd()) & 8'h3f);
      rdc(5'h10, 8'(ctrlM), 8'hff);
    end
    for (int c = 0; c < 8; c++) begin
      wc(8'(c));
      repeat (15) @(posedge clock);
      n = 0;
      repeat (30) begin
        @(posedge clock);
        #1;
        n += int'(dutyOn);
      end
      chk(16'(n), 16'(2 * lit[c]));
    end
    wc(8'h88);
    host_bus_model_i.wr(1'b1, 5'h10, 8'h07);
    // Refused write used two of the three clear cycles
    idle(1);
    ctrlM = ctrlM & 8'h7f;
    blankModel(1);
    rdc(5'h10, 8'(ctrlM), 8'hff);
    for (int i = 0; i < 8; i++) rdc({2'b11, i[2:0]}, 8'h20, 8'hff);
    flashChk();
    rdc(5'h00, 8'(ptrM), 8'h0f);
    charM[0] = 8'h80 | ptrM[3:0];
    host_bus_model_i.wr(1'b1, 5'h18, 8'(charM[0]));
    scanChk(0, 6);
    // Mid-run reset: glyphs and pointer survive
    rst_b = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    ctrlM = 0;
    blankModel(0);
    rdc(5'h10, 8'h00, 8'hff);
    rdc(5'h1c, 8'h20, 8'hff);
    rdc(5'h00, 8'(ptrM), 8'h0f);
    charM[3] = 8'h80 | ptrM[3:0];
    host_bus_model_i.wr(1'b1, 5'h1b, 8'(charM[3]));
    scanChk(3, 2);
    wc(8'h08);
    flashChk();
    for (int t = 0; t < 2; t++) begin
      romPat = t[0];
      s = 35'h0;
      for (int i = 0; i < 128; i++) s = {s[33:0], s[34]} ^ (t == 1 ? {28'h0, i[6:0]} : 35'h0);
      wc(t == 1 ? 8'hdf : 8'h5f);
      idle(TEST_LEN);
      ctrlM = (s == 35'h0) ? 8'h20 : 8'h00;
      blankModel(0);
      rdc(5'h10, 8'(ctrlM), 8'hff);
      rdc(5'h00, 8'hff, 8'hff);
      rdc(5'h1d, 8'h20, 8'hff);
      wc(8'h08);
      flashChk();
    end
    wrap_up();
  end
  initial begin
    #(20000 * 20);
    err_total++;
    wrap_up();
  end
endmodule
